// [hdl/io_port_regs.svh]
/*
  constants for the io port block: widths, reset values, address limits.
  assumes inclusion by bare name from design files.
*/
`ifndef IO_PORT_REGS_SVH
`define IO_PORT_REGS_SVH
`define PORT_WIDTH        8
`define CFG_RESET         8'h00
`define OE_RESET          8'h00
`define OUT_RESET         8'h00
`define CODE_INT_LAST     16'h1B3F
`define REGS_BASE         16'h7B40
`define REGS_LAST         16'h7FFF
`define REGS_ALIAS_BASE   16'h1B40
`define REGS_ALIAS_LAST   16'h1FFF
`define ISO_RAM_BASE      16'h2000
`define ISO_RAM_LAST      16'h27FF
`define DATA_INT_LAST     16'h1B3F
`define PA_T0_BIT         0
`define PA_T1_BIT         1
`define PA_OE_BIT         2
`define PA_CS_BIT         3
`define PA_FWR_BIT        4
`define PA_FRD_BIT        5
`define PA_U0_BIT         6
`define PA_U1_BIT         7
`define PB_T2CLK_BIT      0
`define PB_T2CAP_BIT      1
`define PB_RX1_BIT        2
`define PB_TX1_BIT        3
`define PB_IRQ4_BIT       4
`define PB_IRQ5_BIT       5
`define PB_IRQ6_BIT       6
`define PB_T2OV_BIT       7
`define PC_WR_BIT         6
`define PC_RD_BIT         7
`endif

// [hdl/io_port_pkg.sv]
/*
  types shared by the io port block.
  assumes nothing of its surroundings.
*/
package io_port_pkg;
  typedef logic [7:0] port_t;
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_CODE  = 2'b01,
    ACC_READ  = 2'b10,
    ACC_WRITE = 2'b11
  } access_e;
endpackage

// [hdl/io_pin_cell.sv]
/*
  one 8-bit port: output/enable registers, function mux, synchronised
  pin state.
  assumes pins synchronous-domain inputs after the two-stage sync here.
*/
`timescale 1ns/1ps
`include "io_port_regs.svh"
module io_pin_cell
  import io_port_pkg::*;
#(
  parameter int WIDTH = `PORT_WIDTH,
  parameter logic [WIDTH-1:0] ALT_IS_OUT = '0
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // processor side
  input  wire logic [WIDTH-1:0] out_wdata,
  input  wire logic             out_we,
  input  wire logic [WIDTH-1:0] oe_wdata,
  input  wire logic             oe_we,
  input  wire logic [WIDTH-1:0] cfg_wdata,
  input  wire logic             cfg_we,
  output      logic [WIDTH-1:0] out_q,
  output      logic [WIDTH-1:0] oe_q,
  output      logic [WIDTH-1:0] cfg_q,
  output      logic [WIDTH-1:0] pin_state,
  // alternate functions
  input  wire logic [WIDTH-1:0] alt_out,
  output      logic [WIDTH-1:0] alt_in,
  // pads
  input  wire logic [WIDTH-1:0] pad_in,
  output      logic [WIDTH-1:0] pad_out,
  output      logic [WIDTH-1:0] pad_oe
);
  logic [WIDTH-1:0] out_r, out_nxt, oe_r, oe_nxt, cfg_r, cfg_nxt;
  logic [WIDTH-1:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;

  always_comb begin
    out_nxt   = out_we ? out_wdata : out_r;
    oe_nxt    = oe_we ? oe_wdata : oe_r;
    cfg_nxt   = cfg_we ? cfg_wdata : cfg_r;
    sync1_nxt = pad_in;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_r   <= `OUT_RESET;
      oe_r    <= `OE_RESET;
      cfg_r   <= `CFG_RESET;
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (clk_en) begin
      out_r   <= out_nxt;
      oe_r    <= oe_nxt;
      cfg_r   <= cfg_nxt;
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      // alternate output owns the pad; register and buffer cut off
      assign pad_out[i] = (cfg_r[i] && ALT_IS_OUT[i]) ? alt_out[i]
                                                      : out_r[i];
      assign pad_oe[i]  = (cfg_r[i] && ALT_IS_OUT[i]) ? 1'b1
                                                      : oe_r[i];
    end
  endgenerate

  assign pin_state = sync2_r;
  assign alt_in    = sync2_r;
  assign out_q     = out_r;
  assign oe_q      = oe_r;
  assign cfg_q     = cfg_r;

  chk_reset_input: assert property (@(posedge sys_clk)
    reset |=> (oe_r == '0 && cfg_r == '0))
    else $error("oe or cfg not cleared by reset");
  chk_pin_sync: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !reset ##1 clk_en |=> pin_state == $past(pad_in, 2))
    else $error("pin state not two-stage synchronised");
endmodule

// [hdl/io_port_pin_mux_strobes.sv]
/*
  three 8-bit gpio ports with alternate functions and the qualified
  external memory strobes.
  assumes a processor that drives the register strobes and the raw
  read/write/code strobes with the access address, all on sys_clk.
*/
// Operation
// - three memory-mapped 8-bit ports A, B, C: twenty-four pins
// - output enable 1 drives output data bit; 0 leaves pin input
// - pin-state bit returns actual pin level whatever output enable says
// - per-pin config bit: 0 gpio, 1 alternate function
// - alternate output drives pin; output register and buffer disconnected
// - pin-state still reads pin level under alternate output
// - alternate inputs always see the pin level
// - port A alternates: timers, oe, cs, fast strobes, uart mode-0 outs
// - port B alternates: timer2 inputs, uart1, irq4-6 ins, timer2 out
// - port C bits 7 and 6 carry external read and write strobes
// - chip select = read or write or code; output enable = read or code
// - strobes qualified by address, never for internal regions
// - external code select 0: code below 0x1B40 internal, no code strobe
// - data access to 0x7B40 block or 0x1B40 alias makes no strobe
// - external code select 1: all code fetches external with strobe
// - iso buffer disable 1: 0x2000-0x27FF internal, read and write strobes suppressed
// - reset clears all config and output enable bits
`timescale 1ns/1ps
`include "io_port_regs.svh"
module io_port_pin_mux_strobes
  import io_port_pkg::*;
#(
  parameter int WIDTH = `PORT_WIDTH
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // port register writes, one strobe per register
  input  wire logic [WIDTH-1:0] reg_wdata,
  input  wire logic [2:0]       out_we,
  input  wire logic [2:0]       oe_we,
  input  wire logic [2:0]       function_select_we,
  // register read-back
  output      logic [WIDTH-1:0] port_a_out,
  output      logic [WIDTH-1:0] port_b_out,
  output      logic [WIDTH-1:0] port_c_out,
  output      logic [WIDTH-1:0] port_a_oe,
  output      logic [WIDTH-1:0] port_b_oe,
  output      logic [WIDTH-1:0] port_c_oe,
  output      logic [WIDTH-1:0] port_a_function_select,
  output      logic [WIDTH-1:0] port_b_function_select,
  output      logic [WIDTH-1:0] port_c_function_select,
  output      logic [WIDTH-1:0] port_a_pins,
  output      logic [WIDTH-1:0] port_b_pins,
  output      logic [WIDTH-1:0] port_c_pins,
  // processor memory access
  input  wire logic [15:0]      mem_addr,
  input  wire logic             raw_read_strobe_n,
  input  wire logic             raw_write_strobe_n,
  input  wire logic             raw_code_strobe_n,
  input  wire logic             external_code_select,
  input  wire logic             iso_buffer_disable,
  output      logic             code_fetch_strobe_n,
  output      logic             mem_chip_select_n,
  output      logic             mem_output_enable_n,
  output      logic             ext_read_strobe_n,
  output      logic             ext_write_strobe_n,
  // alternate output sources
  input  wire logic             timer0_overflow_pulse,
  input  wire logic             timer1_overflow_pulse,
  input  wire logic             timer2_overflow_pulse,
  input  wire logic             fast_write_strobe_n,
  input  wire logic             fast_read_strobe_n,
  input  wire logic             uart0_mode0_data_out,
  input  wire logic             uart1_mode0_data_out,
  input  wire logic             uart1_transmit_out,
  input  wire logic [5:0]       port_c_alt_out,
  // alternate input sinks, always listening
  output      logic             timer2_clock_in,
  output      logic             timer2_capture_in,
  output      logic             uart1_receive_in,
  output      logic             irq4_in,
  output      logic             irq5_in,
  output      logic             irq6_in,
  output      logic [5:0]       port_c_alt_in,
  // pads
  input  wire logic [WIDTH-1:0] pad_a_in,
  input  wire logic [WIDTH-1:0] pad_b_in,
  input  wire logic [WIDTH-1:0] pad_c_in,
  output      logic [WIDTH-1:0] pad_a_out,
  output      logic [WIDTH-1:0] pad_b_out,
  output      logic [WIDTH-1:0] pad_c_out,
  output      logic [WIDTH-1:0] pad_a_oe,
  output      logic [WIDTH-1:0] pad_b_oe,
  output      logic [WIDTH-1:0] pad_c_oe
);
  localparam logic [WIDTH-1:0] A_ALT_OUT = 8'hFF;
  localparam logic [WIDTH-1:0] B_ALT_OUT = 8'h88;
  localparam logic [WIDTH-1:0] C_ALT_OUT = 8'hC2;

  logic in_regs, in_iso, code_internal, data_internal;
  logic rd_n_nxt, wr_n_nxt, code_n_nxt;
  logic rd_n_r, wr_n_r, code_n_r;
  logic [WIDTH-1:0] a_alt_out, b_alt_out, c_alt_out;
  logic [WIDTH-1:0] a_alt_in, b_alt_in, c_alt_in;

  ////////////////////////////////////////////////////////////////////////
  // address qualification of the raw strobes
  always_comb begin
    in_regs = (mem_addr >= `REGS_BASE && mem_addr <= `REGS_LAST) ||
              (mem_addr >= `REGS_ALIAS_BASE &&
               mem_addr <= `REGS_ALIAS_LAST);
    in_iso  = iso_buffer_disable && mem_addr >= `ISO_RAM_BASE &&
              mem_addr <= `ISO_RAM_LAST;
    data_internal = (mem_addr <= `DATA_INT_LAST) || in_regs || in_iso;
    code_internal = !external_code_select &&
                    (mem_addr <= `CODE_INT_LAST);
    rd_n_nxt   = raw_read_strobe_n  || data_internal;
    wr_n_nxt   = raw_write_strobe_n || data_internal;
    code_n_nxt = raw_code_strobe_n  || code_internal;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_n_r   <= 1'b1;
      wr_n_r   <= 1'b1;
      code_n_r <= 1'b1;
    end else if (clk_en) begin
      rd_n_r   <= rd_n_nxt;
      wr_n_r   <= wr_n_nxt;
      code_n_r <= code_n_nxt;
    end
  end

  always_comb begin
    code_fetch_strobe_n = code_n_r;
    ext_read_strobe_n   = rd_n_r;
    ext_write_strobe_n  = wr_n_r;
    mem_chip_select_n   = rd_n_r && wr_n_r && code_n_r;
    mem_output_enable_n = rd_n_r && code_n_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // alternate function routing
  always_comb begin
    a_alt_out = '0;
    a_alt_out[`PA_T0_BIT]  = timer0_overflow_pulse;
    a_alt_out[`PA_T1_BIT]  = timer1_overflow_pulse;
    a_alt_out[`PA_OE_BIT]  = mem_output_enable_n;
    a_alt_out[`PA_CS_BIT]  = mem_chip_select_n;
    a_alt_out[`PA_FWR_BIT] = fast_write_strobe_n;
    a_alt_out[`PA_FRD_BIT] = fast_read_strobe_n;
    a_alt_out[`PA_U0_BIT]  = uart0_mode0_data_out;
    a_alt_out[`PA_U1_BIT]  = uart1_mode0_data_out;
    b_alt_out = '0;
    b_alt_out[`PB_TX1_BIT]  = uart1_transmit_out;
    b_alt_out[`PB_T2OV_BIT] = timer2_overflow_pulse;
    c_alt_out = {ext_read_strobe_n, ext_write_strobe_n,
                 port_c_alt_out};
    timer2_clock_in   = b_alt_in[`PB_T2CLK_BIT];
    timer2_capture_in = b_alt_in[`PB_T2CAP_BIT];
    uart1_receive_in  = b_alt_in[`PB_RX1_BIT];
    irq4_in           = b_alt_in[`PB_IRQ4_BIT];
    irq5_in           = b_alt_in[`PB_IRQ5_BIT];
    irq6_in           = b_alt_in[`PB_IRQ6_BIT];
    port_c_alt_in     = c_alt_in[5:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // the three ports
  io_pin_cell #(.WIDTH(WIDTH), .ALT_IS_OUT(A_ALT_OUT)) u_port_a (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .out_wdata(reg_wdata), .out_we(out_we[0]),
    .oe_wdata(reg_wdata), .oe_we(oe_we[0]),
    .cfg_wdata(reg_wdata), .cfg_we(function_select_we[0]),
    .out_q(port_a_out), .oe_q(port_a_oe),
    .cfg_q(port_a_function_select), .pin_state(port_a_pins),
    .alt_out(a_alt_out), .alt_in(a_alt_in),
    .pad_in(pad_a_in), .pad_out(pad_a_out), .pad_oe(pad_a_oe));
  io_pin_cell #(.WIDTH(WIDTH), .ALT_IS_OUT(B_ALT_OUT)) u_port_b (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .out_wdata(reg_wdata), .out_we(out_we[1]),
    .oe_wdata(reg_wdata), .oe_we(oe_we[1]),
    .cfg_wdata(reg_wdata), .cfg_we(function_select_we[1]),
    .out_q(port_b_out), .oe_q(port_b_oe),
    .cfg_q(port_b_function_select), .pin_state(port_b_pins),
    .alt_out(b_alt_out), .alt_in(b_alt_in),
    .pad_in(pad_b_in), .pad_out(pad_b_out), .pad_oe(pad_b_oe));
  io_pin_cell #(.WIDTH(WIDTH), .ALT_IS_OUT(C_ALT_OUT)) u_port_c (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .out_wdata(reg_wdata), .out_we(out_we[2]),
    .oe_wdata(reg_wdata), .oe_we(oe_we[2]),
    .cfg_wdata(reg_wdata), .cfg_we(function_select_we[2]),
    .out_q(port_c_out), .oe_q(port_c_oe),
    .cfg_q(port_c_function_select), .pin_state(port_c_pins),
    .alt_out(c_alt_out), .alt_in(c_alt_in),
    .pad_in(pad_c_in), .pad_out(pad_c_out), .pad_oe(pad_c_oe));

  ////////////////////////////////////////////////////////////////////////
  chk_cs_equation: assert property (@(posedge sys_clk) disable iff (reset)
    mem_chip_select_n == (ext_read_strobe_n && ext_write_strobe_n &&
                          code_fetch_strobe_n))
    else $error("chip select not the or of the strobes");
  chk_oe_equation: assert property (@(posedge sys_clk) disable iff (reset)
    mem_output_enable_n == (ext_read_strobe_n && code_fetch_strobe_n))
    else $error("output enable not the or of read and code");
  chk_code_internal: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !external_code_select && mem_addr <= `CODE_INT_LAST
    |=> code_fetch_strobe_n)
    else $error("code strobe for internal code");
  chk_code_external: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && external_code_select && !raw_code_strobe_n
    |=> !code_fetch_strobe_n)
    else $error("external code fetch lost its strobe");
  chk_regs_silent: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && ((mem_addr >= `REGS_BASE && mem_addr <= `REGS_LAST) ||
    (mem_addr >= `REGS_ALIAS_BASE && mem_addr <= `REGS_ALIAS_LAST))
    |=> ext_read_strobe_n && ext_write_strobe_n)
    else $error("strobe for internal register block");
  chk_iso_silent: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && iso_buffer_disable && mem_addr >= `ISO_RAM_BASE &&
    mem_addr <= `ISO_RAM_LAST |=> ext_read_strobe_n && ext_write_strobe_n)
    else $error("strobe for iso ram region");
  chk_pa_alt_drive: assert property (@(posedge sys_clk) disable iff (reset)
    port_a_function_select[`PA_CS_BIT] |->
    pad_a_oe[`PA_CS_BIT] && pad_a_out[`PA_CS_BIT] == mem_chip_select_n)
    else $error("port a chip select not routed");
  chk_irq_listen: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !reset ##1 clk_en |=>
    irq4_in == $past(pad_b_in[`PB_IRQ4_BIT], 2))
    else $error("alternate input not fed from pin");
  chk_gpio_drive: assert property (@(posedge sys_clk) disable iff (reset)
    !port_b_function_select[`PB_TX1_BIT] |->
    pad_b_oe[`PB_TX1_BIT] == port_b_oe[`PB_TX1_BIT])
    else $error("gpio buffer not following enable");
  cov_ext_read: cover property (@(posedge sys_clk) !ext_read_strobe_n);
  cov_code_fetch: cover property (@(posedge sys_clk) !code_fetch_strobe_n);
  cov_alt_cs: cover property (@(posedge sys_clk)
    port_a_function_select[`PA_CS_BIT] && !pad_a_out[`PA_CS_BIT]);
endmodule

// [bench/ext_pins_model.sv]
/*
  far side of one 8-bit port: the board with its pull-ups and any
  external driver on the pins.
  assumes the design enables its pad buffer with a high pad_oe.
*/
`timescale 1ns/1ps
module ext_pins_model
  import io_port_pkg::*;
(
  // design pad side
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  // board side
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output      port_t      pad_in
);
  // driven pins follow the design; released pins follow the board or
  // fall back to the pull-up level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en);
endmodule

// [bench/io_port_pin_mux_strobes_test.sv]
/*
  self-checking bench: register writes, pin levels, alternate functions
  and the address-qualified memory strobes.
  assumes the design and its package compile first.
*/
`timescale 1ns/1ps
module io_port_pin_mux_strobes_test
  import io_port_pkg::*;
;
  logic sys_clk, reset, clk_en;
  logic [7:0] reg_wdata;
  logic [2:0] out_we, oe_we, function_select_we;
  logic [7:0] a_out, b_out, c_out, a_oe, b_oe, c_oe, a_fs, b_fs, c_fs;
  logic [7:0] a_pins, b_pins, c_pins, a_pout, b_pout, c_pout;
  logic [7:0] a_poe, b_poe, c_poe;
  port_t      a_in, b_in, c_in;
  logic [7:0] ext_en [3];
  logic [7:0] ext_val [3];
  logic [15:0] mem_addr;
  logic rd_n, wr_n, code_n, ecs, iso, cf_n, cs_n, oe_n, erd_n, ewr_n;
  logic t0, t1, t2, fwr_n, frd_n, u0, u1, tx1;
  logic [5:0] c_alt_out, c_alt_in;
  logic t2clk, t2cap, rx1, irq4, irq5, irq6;
  int num_errors, samples_checked;

  io_port_pin_mux_strobes i_dut (.sys_clk(sys_clk), .reset(reset),
    .clk_en(clk_en), .reg_wdata(reg_wdata), .out_we(out_we),
    .oe_we(oe_we), .function_select_we(function_select_we),
    .port_a_out(a_out), .port_b_out(b_out), .port_c_out(c_out),
    .port_a_oe(a_oe), .port_b_oe(b_oe), .port_c_oe(c_oe),
    .port_a_function_select(a_fs), .port_b_function_select(b_fs),
    .port_c_function_select(c_fs), .port_a_pins(a_pins),
    .port_b_pins(b_pins), .port_c_pins(c_pins), .mem_addr(mem_addr),
    .raw_read_strobe_n(rd_n), .raw_write_strobe_n(wr_n),
    .raw_code_strobe_n(code_n), .external_code_select(ecs),
    .iso_buffer_disable(iso), .code_fetch_strobe_n(cf_n),
    .mem_chip_select_n(cs_n), .mem_output_enable_n(oe_n),
    .ext_read_strobe_n(erd_n), .ext_write_strobe_n(ewr_n),
    .timer0_overflow_pulse(t0), .timer1_overflow_pulse(t1),
    .timer2_overflow_pulse(t2), .fast_write_strobe_n(fwr_n),
    .fast_read_strobe_n(frd_n), .uart0_mode0_data_out(u0),
    .uart1_mode0_data_out(u1), .uart1_transmit_out(tx1),
    .port_c_alt_out(c_alt_out), .timer2_clock_in(t2clk),
    .timer2_capture_in(t2cap), .uart1_receive_in(rx1), .irq4_in(irq4),
    .irq5_in(irq5), .irq6_in(irq6), .port_c_alt_in(c_alt_in),
    .pad_a_in(a_in), .pad_b_in(b_in), .pad_c_in(c_in),
    .pad_a_out(a_pout), .pad_b_out(b_pout), .pad_c_out(c_pout),
    .pad_a_oe(a_poe), .pad_b_oe(b_poe), .pad_c_oe(c_poe));
  ext_pins_model i_pa (.pad_out(a_pout), .pad_oe(a_poe),
    .ext_en(ext_en[0]), .ext_val(ext_val[0]), .pad_in(a_in));
  ext_pins_model i_pb (.pad_out(b_pout), .pad_oe(b_poe),
    .ext_en(ext_en[1]), .ext_val(ext_val[1]), .pad_in(b_in));
  ext_pins_model i_pc (.pad_out(c_pout), .pad_oe(c_poe),
    .ext_en(ext_en[2]), .ext_val(ext_val[2]), .pad_in(c_in));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // kind 0 output data, 1 output enable, 2 function select
  task automatic wr(input int kind, input int port, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wdata <= d;
    out_we[port] <= (kind == 0);
    oe_we[port] <= (kind == 1);
    function_select_we[port] <= (kind == 2);
    @(posedge sys_clk);
    out_we <= 3'h0;
    oe_we <= 3'h0;
    function_select_we <= 3'h0;
  endtask

  // one access cycle; ext says whether it must reach the outside
  task automatic acc(input logic [15:0] a, input logic e, input logic i,
                     input access_e k, input logic ext);
    logic [2:0] s;
    s = {!(ext && k == ACC_READ), !(ext && k == ACC_WRITE),
         !(ext && k == ACC_CODE)};
    @(posedge sys_clk);
    mem_addr <= a;
    ecs <= e;
    iso <= i;
    rd_n <= (k != ACC_READ);
    wr_n <= (k != ACC_WRITE);
    code_n <= (k != ACC_CODE);
    tick(1);
    chk("strobes", {13'h0000, s}, {13'h0000, erd_n, ewr_n, cf_n});
    chk("cs oe", {14'h0000, &s, s[2] & s[0]}, {14'h0000, cs_n, oe_n});
    chk("pc7 pc6", {14'h0000, s[2:1]}, {14'h0000, c_pout[7:6]});
    chk("pa3 pa2", {14'h0000, &s, s[2] & s[0]},
        {14'h0000, a_pout[3:2]});
    @(posedge sys_clk);
    {rd_n, wr_n, code_n} <= 3'h7;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    reg_wdata = 8'h00;
    {out_we, oe_we, function_select_we} = 9'h000;
    mem_addr = 16'h0000;
    {rd_n, wr_n, code_n} = 3'h7;
    ecs = 1'b0;
    iso = 1'b0;
    {t0, t1, t2, fwr_n, frd_n, u0, u1, tx1} = 8'hAB;
    c_alt_out = 6'h02;
    ext_en = '{8'h0F, 8'hFF, 8'h0F};
    ext_val = '{8'h0A, 8'h55, 8'h03};
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
    chk("fsel", 16'h0000, {a_fs, b_fs});
    chk("oe", 16'h0000, {a_oe, c_oe});
    // gpio output on the upper nibble, board drives the lower
    wr(0, 0, 8'h55);
    wr(1, 0, 8'hF0);
    tick(1);
    chk("pad a", 16'hF055, {a_poe, a_pout});
    tick(3);
    chk("pins a", 16'h005A, {8'h00, a_pins});
    chk("pins c", 16'h0033, {10'h000, c_alt_in});
    // writes are ignored while the clock enable is low
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(0, 0, 8'hAA);
    clk_en <= 1'b1;
    tick(1);
    chk("out a frozen", 16'h0055, {8'h00, a_out});
    // alternate inputs listen while pins are plain inputs and while they are gpio outputs
    chk("alt in b", 16'h002D,
        {10'h000, irq6, irq5, irq4, rx1, t2cap, t2clk});
    wr(0, 1, 8'h00);
    wr(1, 1, 8'hFF);
    tick(4);
    chk("alt in b out", 16'h0000,
        {10'h000, irq6, irq5, irq4, rx1, t2cap, t2clk});
    chk("b regs", 16'h00FF, {b_out, b_oe});
    chk("pins b", 16'h0000, {8'h00, b_pins});
    // port b alternate outputs on bits 3 and 7
    wr(2, 1, 8'hFF);
    tick(1);
    chk("pb7 pb3", {14'h0000, t2, tx1},
        {14'h0000, b_pout[7], b_pout[3]});
    // port a alternate outputs take over from the data register
    wr(2, 0, 8'hFF);
    tick(1);
    chk("pad a alt", {8'hFF, u1, u0, frd_n, fwr_n, 2'b11, t1, t0},
        {a_poe, a_pout});
    tick(3);
    chk("pins a alt", {8'h00, u1, u0, frd_n, fwr_n, 2'b11, t1, t0},
        {8'h00, a_pins});
    wr(2, 2, 8'hC2);
    tick(1);
    chk("pad c alt", 16'hC202, {c_poe, c_pout & 8'h02});
    acc(16'h8000, 1'b0, 1'b0, ACC_READ, 1'b1);
    acc(16'h7B40, 1'b0, 1'b0, ACC_READ, 1'b0);
    acc(16'h1B40, 1'b0, 1'b0, ACC_WRITE, 1'b0);
    acc(16'h0100, 1'b0, 1'b0, ACC_CODE, 1'b0);
    acc(16'h1B3F, 1'b0, 1'b0, ACC_CODE, 1'b0);
    acc(16'h1B40, 1'b0, 1'b0, ACC_CODE, 1'b1);
    acc(16'h0100, 1'b1, 1'b0, ACC_CODE, 1'b1);
    acc(16'h2000, 1'b0, 1'b1, ACC_WRITE, 1'b0);
    acc(16'h27FF, 1'b0, 1'b1, ACC_READ, 1'b0);
    acc(16'h2000, 1'b0, 1'b0, ACC_WRITE, 1'b1);
    acc(16'h2800, 1'b0, 1'b1, ACC_READ, 1'b1);
    // reset in mid-run clears the configuration again
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
    chk("fsel rst", 16'h0000, {a_fs, c_fs});
    chk("oe rst", 16'h0000, {a_oe, b_oe});
    close_out();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
endmodule
